/* rtl/dac_port.v */
// palette dac transfer sequencer over eight memory data bus lines
`timescale 1ns/100ps
`include "nad_consts.vh"
module dac_port #(
	parameter DATA_W = 8,
	parameter [7:0] STROBE_CYC = `NAD_DAC_STROBE_CYC
) (
	// clock and reset
	input wire clock_i,
	input wire rst_n_i,
	// request side
	input wire start_i,
	input wire write_i,
	input wire [3:0] code_i,
	input wire [DATA_W-1:0] wdata_i,
	output reg busy_o,
	output reg [DATA_W-1:0] rdata_o,
	// memory work that goes first
	input wire refresh_pending_i,
	input wire reload_pending_i,
	// dac side
	input wire [DATA_W-1:0] bus_i,
	output reg [DATA_W-1:0] bus_o,
	output reg bus_oe_o,
	output reg [3:0] code_o,
	output reg rd_o,
	output reg wr_o
);
	localparam ST_IDLE = 2'd0;
	localparam ST_WAIT = 2'd1;
	localparam ST_ACC = 2'd2;
	reg [1:0] state_q;
	reg [7:0] cnt_q;
	reg wr_q;
	// wait state ends as soon as no refresh or reload is pending
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= ST_IDLE;
			cnt_q <= 8'h00;
			wr_q <= 1'b0;
			busy_o <= 1'b0;
			rdata_o <= {DATA_W{1'b0}};
			bus_o <= {DATA_W{1'b0}};
			bus_oe_o <= 1'b0;
			code_o <= 4'h0;
			rd_o <= 1'b0;
			wr_o <= 1'b0;
		end else begin
			case (state_q)
			ST_IDLE: begin
				if (start_i) begin
					state_q <= ST_WAIT;
					busy_o <= 1'b1;
					wr_q <= write_i;
					code_o <= code_i;
					bus_o <= wdata_i;
				end
			end
			ST_WAIT: begin
				if (!refresh_pending_i && !reload_pending_i) begin
					state_q <= ST_ACC;
					cnt_q <= STROBE_CYC - 8'h01;
					rd_o <= !wr_q;
					wr_o <= wr_q;
					bus_oe_o <= wr_q;
				end
			end
			ST_ACC: begin
				if (cnt_q == 8'h00) begin
					state_q <= ST_IDLE;
					rd_o <= 1'b0;
					wr_o <= 1'b0;
					bus_oe_o <= 1'b0;
					busy_o <= 1'b0;
					if (!wr_q) begin
						rdata_o <= bus_i;
					end
				end else begin
					cnt_q <= cnt_q - 8'h01;
				end
			end
			default: state_q <= ST_IDLE;
			endcase
		end
	end
endmodule

/* rtl/nad_consts.vh */
// constants for the native access address decoder
`ifndef NAD_CONSTS_VH
`define NAD_CONSTS_VH
// prefix fields, bits 31:15 of the host address
`define NAD_PFX_IND 17'h0_0014
`define NAD_WB_HI 31
`define NAD_WB_LO 24
`define NAD_SW_H 18
`define NAD_SW_B 17
`define NAD_SW_BIT 16
// select patterns, compared against the high end of bits 14:2
`define NAD_SEL_SYS 8'h00
`define NAD_SEL_VID 8'h02
`define NAD_SEL_MEM 8'h03
`define NAD_SEL_PECTL 8'h43
`define NAD_SEL_BITPIX 8'h41
`define NAD_SEL_PECOORD 7'h30
`define NAD_SEL_LOADC 6'h19
`define NAD_SEL_DRAW 6'h11
`define NAD_SEL_DAC 6'h01
`define NAD_SEL_VCP 5'h01
// full 13-bit word addresses, bits 14:2
`define NAD_A_STATUS 13'h0800
`define NAD_A_BLIT 13'h0801
`define NAD_A_QUAD 13'h0802
`define NAD_A_BYTEPIX 13'h0803
`define NAD_A_NEXTPIX 13'h0805
// decoded target codes; 1..7 map onto the register group select bits
`define NAD_T_NONE 4'h0
`define NAD_T_SYS 4'h1
`define NAD_T_VID 4'h2
`define NAD_T_MEM 4'h3
`define NAD_T_PECTL 4'h4
`define NAD_T_PECOORD 4'h5
`define NAD_T_LOADC 4'h6
`define NAD_T_DRAW 4'h7
`define NAD_T_DAC 4'h8
`define NAD_T_VCP 4'h9
`define NAD_T_STATUS 4'ha
`define NAD_T_BLIT 4'hb
`define NAD_T_QUAD 4'hc
`define NAD_T_BYTEPIX 4'hd
`define NAD_T_NEXTPIX 4'he
`define NAD_T_BITPIX 4'hf
// timing and reset values
`define NAD_DAC_STROBE_CYC 8'h02
`define NAD_VCP_STROBE_CYC 8'h02
`define NAD_RDATA_RST 32'h0000_0000
`endif

/* rtl/native_access_address_decoder.v */
// native access address decoder: prefix check, target decode and forwarding
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
`include "nad_consts.vh"
//
// Contract
// - writes start byte, next and bit pixel commands
// - reads give status, launch blit or quad
// - bits 14:7 select four control register groups
// - bits 14:8/14:9 select coordinate and load-coordinate
// - bits 14:9 010001 select pixel processing registers
// - bits 14:9 000001 is dac, code bits 5:2; the code also needs bits 8:6 zero
// - dac access starts at once, ends quickly
// - dac stall bounded; refresh and reload first
// - dac byte over eight memory data lines
// - bits 14:10 00001 is coprocessor, register 9:2
// - coprocessor access starts at once, ends quickly
// - coprocessor interface only active in native mode
// - shared pins follow the current operating mode
// - registers 32 bits, writable unless read only
// - direct prefix: window base and swap bits
// - indirect prefix only when enabled, swaps from config
module native_access_address_decoder #(
	parameter VCP_W = 8
) (
	// clock and reset
	input wire clock_i,
	input wire rst_n_i,
	// host register port
	input wire [31:0] addr_i,
	input wire [31:0] wdata_i,
	input wire we_i,
	input wire re_i,
	output reg [31:0] rdata_o,
	// configuration
	input wire native_mode_i,
	input wire [7:0] window_base_i,
	input wire indirect_access_enable_i,
	input wire [2:0] config_swap_i,
	// register groups and commands
	output reg [6:0] target_o,
	output reg [12:0] reg_index_o,
	output reg [31:0] reg_wdata_o,
	output reg reg_wr_o,
	output reg reg_rd_o,
	input wire [31:0] reg_rdata_i,
	input wire [31:0] status_i,
	output reg [4:0] cmd_o,
	// palette dac
	input wire refresh_pending_i,
	input wire reload_pending_i,
	input wire [7:0] memory_data_bus_i,
	output wire [7:0] memory_data_bus_o,
	output wire memory_data_bus_oe_o,
	output wire [3:0] dac_transfer_code_o,
	output wire dac_rd_o,
	output wire dac_wr_o,
	output wire dac_busy_o,
	// video coprocessor and shared pins
	input wire [VCP_W-1:0] emu_pin_i,
	input wire emu_pin_oe_i,
	input wire [VCP_W-1:0] vcp_pin_i,
	output wire [VCP_W-1:0] vcp_pin_o,
	output wire vcp_pin_oe_o,
	output wire [7:0] vcp_reg_o,
	output wire vcp_rd_o,
	output wire vcp_wr_o,
	output wire vcp_busy_o
);
	localparam CMD_BYTEPIX = 0;
	localparam CMD_NEXTPIX = 1;
	localparam CMD_BITPIX = 2;
	localparam CMD_BLIT = 3;
	localparam CMD_QUAD = 4;

	// decode shared by both directions: register groups, dac and coprocessor
	function [3:0] group_code;
		input [12:0] a;
		begin
			if (a[12:5] == `NAD_SEL_SYS) begin
				group_code = `NAD_T_SYS;
			end else if (a[12:5] == `NAD_SEL_VID) begin
				group_code = `NAD_T_VID;
			end else if (a[12:5] == `NAD_SEL_MEM) begin
				group_code = `NAD_T_MEM;
			end else if (a[12:5] == `NAD_SEL_PECTL) begin
				group_code = `NAD_T_PECTL;
			end else if (a[12:6] == `NAD_SEL_PECOORD) begin
				group_code = `NAD_T_PECOORD;
			end else if (a[12:7] == `NAD_SEL_LOADC) begin
				group_code = `NAD_T_LOADC;
			end else if (a[12:7] == `NAD_SEL_DRAW) begin
				group_code = `NAD_T_DRAW;
			end else if (a[12:7] == `NAD_SEL_DAC && a[6:4] == 3'b000) begin
				group_code = `NAD_T_DAC;
			end else if (a[12:8] == `NAD_SEL_VCP) begin
				group_code = `NAD_T_VCP;
			end else begin
				group_code = `NAD_T_NONE;
			end
		end
	endfunction

	// write-only words: the pixel commands win over the shared table
	function [3:0] write_code;
		input [12:0] a;
		begin
			if (a[12]) begin
				write_code = `NAD_T_BYTEPIX;
			end else if (a == `NAD_A_BYTEPIX) begin
				write_code = `NAD_T_BYTEPIX;
			end else if (a == `NAD_A_NEXTPIX) begin
				write_code = `NAD_T_NEXTPIX;
			end else if (a[12:5] == `NAD_SEL_BITPIX) begin
				write_code = `NAD_T_BITPIX;
			end else begin
				write_code = group_code(a);
			end
		end
	endfunction

	// read-only words: status and the two commands that a read launches
	function [3:0] read_code;
		input [12:0] a;
		begin
			if (a == `NAD_A_STATUS) begin
				read_code = `NAD_T_STATUS;
			end else if (a == `NAD_A_BLIT) begin
				read_code = `NAD_T_BLIT;
			end else if (a == `NAD_A_QUAD) begin
				read_code = `NAD_T_QUAD;
			end else if (a[12]) begin
				read_code = `NAD_T_NONE;
			end else begin
				read_code = group_code(a);
			end
		end
	endfunction

	// endian swaps; each is an involution and they commute, so reads reuse it
	function [31:0] swap32;
		input [31:0] d;
		input [2:0] s;
		reg [31:0] t;
		integer i;
		begin
			t = d;
			if (s[0]) begin
				for (i = 0; i < 32; i = i + 1) begin
					t[i] = d[(i / 8) * 8 + 7 - (i % 8)];
				end
			end
			if (s[1]) begin
				t = {t[23:16], t[31:24], t[7:0], t[15:8]};
			end
			if (s[2]) begin
				t = {t[15:0], t[31:16]};
			end
			swap32 = t;
		end
	endfunction

	// prefix check; direct and indirect prefixes cannot both match
	wire direct_ok;
	wire indirect_ok;
	wire acc_ok;
	wire [2:0] swap_sel;
	assign direct_ok = (addr_i[`NAD_WB_HI:`NAD_WB_LO] == window_base_i)
		&& (addr_i[23:19] == 5'h00) && !addr_i[15];
	assign indirect_ok = indirect_access_enable_i
		&& (addr_i[31:15] == `NAD_PFX_IND);
	assign acc_ok = direct_ok | indirect_ok;
	// direct accesses carry their swaps in the address itself
	wire [2:0] addr_swap;
	assign addr_swap = {addr_i[`NAD_SW_H], addr_i[`NAD_SW_B], addr_i[`NAD_SW_BIT]};
	// indirect accesses take their swaps from configuration
	assign swap_sel = indirect_ok ? config_swap_i : addr_swap;

	// target of the current strobe; the direction picks the decode table
	wire [12:0] word_ix;
	wire [3:0] tsel;
	wire strobe;
	wire [31:0] wdata_sw;
	assign word_ix = addr_i[14:2];
	assign strobe = we_i | re_i;
	assign tsel = !acc_ok ? `NAD_T_NONE
		: we_i ? write_code(word_ix) : read_code(word_ix);
	assign wdata_sw = swap32(wdata_i, swap_sel);

	// one select bit per register group
	wire [6:0] grp_hit;
	genvar g;
	generate
		for (g = 0; g < 7; g = g + 1) begin : grp
			localparam [3:0] CODE = g + 1;
			assign grp_hit[g] = (tsel == CODE);
		end
	endgenerate
	wire is_grp;
	assign is_grp = |grp_hit;

	// sequencer handshakes
	wire dac_start;
	wire vcp_start;
	wire [7:0] dac_rdata;
	wire [VCP_W-1:0] vcp_rdata;
	// a new dac or coprocessor access while one is busy is dropped
	assign dac_start = strobe && tsel == `NAD_T_DAC && !dac_busy_o;
	assign vcp_start = strobe && tsel == `NAD_T_VCP && !vcp_busy_o
		&& native_mode_i;

	// read data source for the cycle after a read strobe
	reg [31:0] rsrc;
	always @* begin
		rsrc = `NAD_RDATA_RST;
		case (tsel)
		`NAD_T_STATUS: rsrc = status_i;
		`NAD_T_BLIT: rsrc = status_i;
		`NAD_T_QUAD: rsrc = status_i;
		`NAD_T_DAC: rsrc = {24'h00_0000, dac_rdata};
		`NAD_T_VCP: rsrc = {{(32 - VCP_W){1'b0}}, vcp_rdata};
		default: rsrc = is_grp ? reg_rdata_i : `NAD_RDATA_RST;
		endcase
	end

	// forwarding to register groups; strobes are one-cycle pulses
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			target_o <= 7'h00;
			reg_index_o <= 13'h0000;
			reg_wdata_o <= 32'h0000_0000;
			reg_wr_o <= 1'b0;
			reg_rd_o <= 1'b0;
		end else begin
			reg_wr_o <= 1'b0;
			reg_rd_o <= 1'b0;
			if (strobe && is_grp) begin
				target_o <= grp_hit;
				reg_index_o <= addr_i[14:2];
				reg_wr_o <= we_i;
				reg_rd_o <= re_i;
			end
			// any mapped write leaves its swapped data for the target
			if (we_i && tsel != `NAD_T_NONE) begin
				reg_wdata_o <= wdata_sw;
			end
			// command writes leave their word index for the engines
			if (we_i && tsel >= `NAD_T_BYTEPIX) begin
				reg_index_o <= addr_i[14:2];
			end
		end
	end

	// target code behind each command bit
	function [3:0] cmd_code;
		input integer k;
		begin
			case (k)
			CMD_BYTEPIX: cmd_code = `NAD_T_BYTEPIX;
			CMD_NEXTPIX: cmd_code = `NAD_T_NEXTPIX;
			CMD_BITPIX: cmd_code = `NAD_T_BITPIX;
			CMD_BLIT: cmd_code = `NAD_T_BLIT;
			default: cmd_code = `NAD_T_QUAD;
			endcase
		end
	endfunction

	// writes launch the pixel commands, reads launch blit and quad
	wire [4:0] cmd_hit;
	genvar c;
	generate
		for (c = 0; c < 5; c = c + 1) begin : cmd_bit
			assign cmd_hit[c] = ((c < CMD_BLIT) ? we_i : re_i) && tsel == cmd_code(c);
		end
	endgenerate

	// command launches are one-cycle pulses
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cmd_o <= 5'h00;
		end else begin
			cmd_o <= cmd_hit;
		end
	end

	// read data; unmatched reads return zero and touch nothing
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= `NAD_RDATA_RST;
		end else if (re_i) begin
			rdata_o <= swap32(rsrc, swap_sel);
		end
	end

	// palette dac; bits 1:0 are not checked, the host keeps them zero
	dac_port #(
		.DATA_W(8),
		.STROBE_CYC(`NAD_DAC_STROBE_CYC)
	) u_dac (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.start_i(dac_start),
		.write_i(we_i),
		.code_i(addr_i[5:2]),
		.wdata_i(wdata_sw[7:0]),
		.busy_o(dac_busy_o),
		.rdata_o(dac_rdata),
		.refresh_pending_i(refresh_pending_i),
		.reload_pending_i(reload_pending_i),
		.bus_i(memory_data_bus_i),
		.bus_o(memory_data_bus_o),
		.bus_oe_o(memory_data_bus_oe_o),
		.code_o(dac_transfer_code_o),
		.rd_o(dac_rd_o),
		.wr_o(dac_wr_o)
	);

	// video coprocessor on pins shared with emulation mode
	vcp_port #(
		.DATA_W(VCP_W),
		.STROBE_CYC(`NAD_VCP_STROBE_CYC)
	) u_vcp (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.native_i(native_mode_i),
		.start_i(vcp_start),
		.write_i(we_i),
		.reg_i(addr_i[9:2]),
		.wdata_i(wdata_sw[VCP_W-1:0]),
		.busy_o(vcp_busy_o),
		.rdata_o(vcp_rdata),
		.emu_i(emu_pin_i),
		.emu_oe_i(emu_pin_oe_i),
		.pin_i(vcp_pin_i),
		.pin_o(vcp_pin_o),
		.pin_oe_o(vcp_pin_oe_o),
		.reg_o(vcp_reg_o),
		.rd_o(vcp_rd_o),
		.wr_o(vcp_wr_o)
	);
endmodule

/* rtl/vcp_port.v */
// video coprocessor access sequencer with pins shared with emulation mode
`timescale 1ns/100ps
`include "nad_consts.vh"
module vcp_port #(
	parameter DATA_W = 8,
	parameter [7:0] STROBE_CYC = `NAD_VCP_STROBE_CYC
) (
	// clock and reset
	input wire clock_i,
	input wire rst_n_i,
	// request side
	input wire native_i,
	input wire start_i,
	input wire write_i,
	input wire [7:0] reg_i,
	input wire [DATA_W-1:0] wdata_i,
	output reg busy_o,
	output reg [DATA_W-1:0] rdata_o,
	// shared pins
	input wire [DATA_W-1:0] emu_i,
	input wire emu_oe_i,
	input wire [DATA_W-1:0] pin_i,
	output reg [DATA_W-1:0] pin_o,
	output reg pin_oe_o,
	output reg [7:0] reg_o,
	output reg rd_o,
	output reg wr_o
);
	localparam ST_IDLE = 2'd0;
	localparam ST_ACC = 2'd1;
	localparam ST_DONE = 2'd2;
	reg [1:0] state_q;
	reg [7:0] cnt_q;
	reg rd_q;
	reg wr_q;
	reg [DATA_W-1:0] dout_q;
	// core sequence; leaving native mode drops any access in flight
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= ST_IDLE;
			cnt_q <= 8'h00;
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			dout_q <= {DATA_W{1'b0}};
			busy_o <= 1'b0;
			rdata_o <= {DATA_W{1'b0}};
			reg_o <= 8'h00;
		end else if (!native_i) begin
			state_q <= ST_IDLE;
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			busy_o <= 1'b0;
		end else begin
			case (state_q)
			ST_IDLE: begin
				if (start_i) begin
					state_q <= ST_ACC;
					cnt_q <= STROBE_CYC - 8'h01;
					busy_o <= 1'b1;
					rd_q <= !write_i;
					wr_q <= write_i;
					reg_o <= reg_i;
					dout_q <= wdata_i;
				end
			end
			ST_ACC: begin
				if (cnt_q == 8'h00) begin
					state_q <= ST_DONE;
					wr_q <= 1'b0;
					rd_q <= 1'b0;
				end else begin
					cnt_q <= cnt_q - 8'h01;
				end
			end
			ST_DONE: begin
				// pins lag the core by one stage, so the read strobe is still out
				state_q <= ST_IDLE;
				busy_o <= 1'b0;
				if (rd_o) begin
					rdata_o <= pin_i;
				end
			end
			default: state_q <= ST_IDLE;
			endcase
		end
	end
	// pin stage follows the operating mode
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_o <= {DATA_W{1'b0}};
			pin_oe_o <= 1'b0;
			rd_o <= 1'b0;
			wr_o <= 1'b0;
		end else begin
			pin_o <= native_i ? dout_q : emu_i;
			pin_oe_o <= native_i ? wr_q : emu_oe_i;
			rd_o <= native_i & rd_q;
			wr_o <= native_i & wr_q;
		end
	end
endmodule

/* tb/far_end.sv */
// palette dac and video coprocessor stand-in on the far side
`timescale 1ns/100ps
module far_end (
	// clock
	input logic clock_i,
	// dac side
	input logic [7:0] memory_data_bus_o,
	input logic memory_data_bus_oe_o, dac_rd_o,
	input logic [3:0] dac_transfer_code_o,
	output logic [7:0] memory_data_bus_i,
	// coprocessor side
	input logic [7:0] vcp_pin_o, vcp_reg_o,
	input logic vcp_pin_oe_o, vcp_rd_o,
	output logic [7:0] vcp_pin_i
);
	logic [7:0] junk_q = 8'h3c;
	// released lines wander each cycle so a stale capture cannot pass by luck
	always @(posedge clock_i) begin
		junk_q <= {junk_q[6:0], ~junk_q[7]};
	end
	// a read strobe gets an answer tied to what was asked
	assign memory_data_bus_i = memory_data_bus_oe_o ? memory_data_bus_o :
		dac_rd_o ? {4'h9, dac_transfer_code_o} : junk_q;
	assign vcp_pin_i = vcp_pin_oe_o ? vcp_pin_o : vcp_rd_o ? {vcp_reg_o[3:0], 4'h6} : ~junk_q;
endmodule

/* tb/nad_assertions.sv */
// concurrent checks on the native access address decoder ports
`timescale 1ns/100ps
`include "nad_consts.vh"
module nad_assertions #(
	parameter VCP_W = 8
) (
	// clock, reset and host port
	input logic clock_i, rst_n_i, we_i, re_i,
	input logic [31:0] addr_i, rdata_o,
	// configuration
	input logic native_mode_i, indirect_access_enable_i,
	input logic [7:0] window_base_i,
	// decoded outputs
	input logic [6:0] target_o,
	input logic [4:0] cmd_o,
	input logic reg_wr_o, reg_rd_o,
	// dac and coprocessor
	input logic refresh_pending_i, reload_pending_i, memory_data_bus_oe_o,
	input logic dac_wr_o, dac_rd_o, dac_busy_o, vcp_wr_o, vcp_rd_o,
	input logic emu_pin_oe_i, vcp_pin_oe_o,
	input logic [3:0] dac_transfer_code_o,
	input logic [VCP_W-1:0] emu_pin_i, vcp_pin_o
);
	logic hit;
	logic [12:0] ix;
	// prefix match, direct or enabled indirect
	assign hit = (addr_i[31:24] == window_base_i && addr_i[23:19] == 5'h00 && !addr_i[15]) ||
		(indirect_access_enable_i && addr_i[31:15] == `NAD_PFX_IND);
	assign ix = addr_i[14:2];
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	// a write strobe drives the lines for its whole length
	sequence dac_strobe_s;
		(dac_wr_o && memory_data_bus_oe_o) [*2] ##1 !dac_wr_o;
	endsequence
	sequence native_off_s;
		!native_mode_i [*3];
	endsequence
	chk_pe_ctl_sel: assert property (we_i && hit && ix[12:5] == `NAD_SEL_PECTL |=>
		reg_wr_o && target_o == 7'h08) else $error("pe control write missed");
	chk_bytepix_cmd: assert property (we_i && hit && (addr_i[14] || ix == `NAD_A_BYTEPIX) |=>
		cmd_o == 5'h01) else $error("byte pixel command missed");
	chk_blit_read: assert property (re_i && hit && ix == `NAD_A_BLIT |=>
		cmd_o == 5'h08) else $error("blit command missed");
	chk_bit14_read: assert property (re_i && hit && addr_i[14] |=>
		cmd_o == 5'h00 && !reg_rd_o && rdata_o == 32'h0000_0000) else $error("bit 14 read acted");
	chk_no_prefix: assert property ((we_i || re_i) && !hit |=>
		!reg_wr_o && !reg_rd_o && cmd_o == 5'h00) else $error("unmatched prefix acted");
	chk_dac_start: assert property (we_i && hit && ix[12:4] == {`NAD_SEL_DAC, 3'h0} &&
		!dac_busy_o |=> (dac_busy_o && dac_transfer_code_o == $past(addr_i[5:2])) ##[0:40]
		dac_wr_o) else $error("dac write not started");
	chk_dac_stall: assert property (dac_busy_o && !dac_wr_o && !dac_rd_o &&
		(refresh_pending_i || reload_pending_i) |=> !dac_wr_o && !dac_rd_o)
		else $error("dac ran ahead of memory work");
	chk_dac_drive: assert property ($rose(dac_wr_o) |-> dac_strobe_s)
		else $error("dac write strobe or drive wrong");
	chk_vcp_idle: assert property (native_off_s |-> !vcp_rd_o && !vcp_wr_o)
		else $error("coprocessor active outside native mode");
	chk_pin_follow: assert property (native_off_s |-> vcp_pin_o == $past(emu_pin_i) &&
		vcp_pin_oe_o == $past(emu_pin_oe_i)) else $error("shared pins ignore emulation");
endmodule

bind native_access_address_decoder nad_assertions #(.VCP_W(VCP_W)) i_chk (.*);

/* tb/tb.sv */
// self-checking bench for the native access address decoder
`timescale 1ns/100ps
`include "nad_consts.vh"
module tb;
	logic clock_i = 0, rst_n_i = 0, we_i = 0, re_i = 0, native_mode_i = 1, emu_pin_oe_i = 0;
	logic indirect_access_enable_i = 0, refresh_pending_i = 0, reload_pending_i = 0;
	logic [31:0] addr_i = 32'h0000_0000, wdata_i = 32'h1234_56c3, e;
	logic [31:0] reg_rdata_i = 32'h1e2d_3c4b, status_i = 32'h8421_0f3c;
	logic [7:0] window_base_i = 8'h5a, emu_pin_i = 8'h00, memory_data_bus_i, vcp_pin_i;
	logic [2:0] config_swap_i = 3'h5;
	wire [31:0] rdata_o, reg_wdata_o;
	wire [6:0] target_o;
	wire [12:0] reg_index_o;
	wire [4:0] cmd_o;
	wire [7:0] memory_data_bus_o, vcp_pin_o, vcp_reg_o;
	wire [3:0] dac_transfer_code_o;
	wire reg_wr_o, reg_rd_o, memory_data_bus_oe_o, dac_rd_o, dac_wr_o, dac_busy_o;
	wire vcp_pin_oe_o, vcp_rd_o, vcp_wr_o, vcp_busy_o;
	int bad_count = 0, n_compared = 0, cyc = 0;
	// rows: write, word index 14:2, swap, expected group, expected command
	logic [28:0] r;
	logic [28:0] rows [0:16] = '{{1'b1, 13'h0005, 3'h1, 7'h01, 5'h00},
		{1'b0, 13'h0043, 3'h2, 7'h02, 5'h00}, {1'b1, 13'h0061, 3'h4, 7'h04, 5'h00},
		{1'b0, 13'h0862, 3'h7, 7'h08, 5'h00}, {1'b1, 13'h0c07, 3'h3, 7'h10, 5'h00},
		{1'b0, 13'h0c81, 3'h5, 7'h20, 5'h00}, {1'b1, 13'h0885, 3'h6, 7'h40, 5'h00},
		{1'b1, 13'h0803, 3'h0, 7'h00, 5'h01}, {1'b1, 13'h1234, 3'h0, 7'h00, 5'h01},
		{1'b1, 13'h0805, 3'h0, 7'h00, 5'h02}, {1'b1, 13'h0827, 3'h0, 7'h00, 5'h04},
		{1'b0, 13'h0800, 3'h5, 7'h00, 5'h00}, {1'b0, 13'h0801, 3'h0, 7'h00, 5'h08},
		{1'b0, 13'h0802, 3'h0, 7'h00, 5'h10}, {1'b0, 13'h1234, 3'h0, 7'h00, 5'h00},
		{1'b1, 13'h0800, 3'h0, 7'h00, 5'h00}, {1'b0, 13'h0400, 3'h0, 7'h00, 5'h00}};
	native_access_address_decoder #(.VCP_W(8)) i_dut (.*);
	far_end i_far (.*);
	always #12.5 clock_i = ~clock_i;
	// swaps commute, so the order of the three steps does not matter
	function automatic logic [31:0] sw(input logic [2:0] s, input logic [31:0] d);
		logic [31:0] t;
		t = s[2] ? {d[15:0], d[31:16]} : d;
		if (s[1]) t = {t[23:16], t[31:24], t[7:0], t[15:8]};
		d = t;
		for (int i = 0; i < 32; i++) if (s[0]) t[i] = d[i - i % 8 + 7 - i % 8];
		return t;
	endfunction
	function automatic logic [31:0] da(input logic [2:0] s, input logic [12:0] ix);
		return {window_base_i, 5'h00, s, 1'b0, ix, 2'h0};
	endfunction
	task chk(input string n, input logic [31:0] s, input logic [31:0] x);
		n_compared++;
		if (s !== x) begin
			bad_count++;
			$display("BAD %s exp %h seen %h", n, x, s);
		end
	endtask
	// one strobe cycle, then look at the answer cycle
	task acc(input logic w, input logic [31:0] a);
		@(posedge clock_i);
		we_i <= w;
		re_i <= !w;
		addr_i <= a;
		@(posedge clock_i);
		we_i <= 0;
		re_i <= 0;
		@(negedge clock_i);
	endtask
	task print_verdict;
		if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clock_i);
		chk("rst rdata", rdata_o, 32'h0000_0000);
		chk("rst outs", {target_o, cmd_o, reg_wr_o, reg_rd_o, dac_busy_o, vcp_pin_oe_o}, 32'h0000_0000);
		repeat (6) @(posedge clock_i);
		rst_n_i <= 1;
		foreach (rows[k]) begin
			r = rows[k];
			acc(r[28], da(r[14:12], r[27:15]));
			chk("wr", reg_wr_o, r[28] && r[11:5] != 0);
			chk("rd", reg_rd_o, !r[28] && r[11:5] != 0);
			chk("cmd", cmd_o, r[4:0]);
			if (r[11:5] != 0) chk("tgt", target_o, r[11:5]);
			if (r[11:5] != 0 || r[28] && r[4:0] != 0) chk("idx", reg_index_o, r[27:15]);
			if (r[28] && r[11:5] != 0) chk("wdat", reg_wdata_o, sw(r[14:12], wdata_i));
			e = r[27:17] == 11'h200 && r[16:15] != 2'h3 ? sw(r[14:12], status_i) : 32'h0000_0000;
			if (r[11:5] != 0) e = sw(r[14:12], reg_rdata_i);
			if (!r[28]) chk("rdat", rdata_o, e);
		end
		// wrong window base, bit 15 set, indirect prefix off then on
		acc(1, da(3'h0, 13'h0005) ^ 32'h0100_0000);
		chk("base", reg_wr_o, 0);
		acc(1, da(3'h0, 13'h0005) | 32'h0000_8000);
		chk("bit15", reg_wr_o, 0);
		acc(1, {`NAD_PFX_IND, 13'h0061, 2'h0});
		chk("ind off", reg_wr_o, 0);
		@(posedge clock_i);
		indirect_access_enable_i <= 1;
		acc(1, {`NAD_PFX_IND, 13'h0061, 2'h0});
		chk("ind on", {target_o, reg_wr_o}, 8'h09);
		chk("ind wdat", reg_wdata_o, sw(config_swap_i, wdata_i));
		// dac write held back while a refresh is pending
		@(posedge clock_i);
		wdata_i <= 32'hc3c3_c3c3;
		refresh_pending_i <= 1;
		acc(1, da(3'h0, {6'h01, 3'h0, 4'ha}));
		chk("dac start", {dac_busy_o, dac_transfer_code_o}, 5'h1a);
		repeat (4) @(negedge clock_i);
		chk("dac stall", dac_wr_o, 0);
		@(posedge clock_i);
		refresh_pending_i <= 0;
		for (int i = 0; i < 8 && dac_wr_o !== 1'b1; i++) @(negedge clock_i);
		chk("dac bus", {dac_wr_o, memory_data_bus_oe_o, memory_data_bus_o}, 10'h3c3);
		for (int i = 0; i < 9 && dac_busy_o !== 1'b0; i++) @(negedge clock_i);
		// dac reads are posted: the second one returns the byte of the first
		@(posedge clock_i);
		reload_pending_i <= 1;
		acc(0, da(3'h0, {6'h01, 3'h0, 4'h3}));
		repeat (2) @(negedge clock_i);
		chk("dac reload", {dac_busy_o, dac_rd_o}, 2'h2);
		@(posedge clock_i);
		reload_pending_i <= 0;
		for (int i = 0; i < 9 && dac_busy_o !== 1'b0; i++) @(negedge clock_i);
		acc(0, da(3'h0, {6'h01, 3'h0, 4'h5}));
		chk("dac read", rdata_o, 32'h0000_0093);
		for (int i = 0; i < 9 && dac_busy_o !== 1'b0; i++) @(negedge clock_i);
		// coprocessor write, then posted read pair
		@(posedge clock_i);
		wdata_i <= 32'ha5a5_a5a5;
		acc(1, da(3'h0, {5'h01, 8'h3c}));
		for (int i = 0; i < 8 && vcp_wr_o !== 1'b1; i++) @(negedge clock_i);
		chk("vcp wr", {vcp_reg_o, vcp_pin_o, vcp_pin_oe_o}, {8'h3c, 8'ha5, 1'b1});
		for (int i = 0; i < 9 && vcp_busy_o !== 1'b0; i++) @(negedge clock_i);
		acc(0, da(3'h0, {5'h01, 8'h3c}));
		for (int i = 0; i < 9 && vcp_busy_o !== 1'b0; i++) @(negedge clock_i);
		acc(0, da(3'h0, {5'h01, 8'h11}));
		chk("vcp read", rdata_o, 32'h0000_00c6);
		for (int i = 0; i < 9 && vcp_busy_o !== 1'b0; i++) @(negedge clock_i);
		// emulation mode hands the pins over and drops coprocessor work
		@(posedge clock_i);
		native_mode_i <= 0;
		emu_pin_i <= 8'h96;
		emu_pin_oe_i <= 1;
		acc(1, da(3'h0, {5'h01, 8'h3c}));
		repeat (3) @(negedge clock_i);
		chk("emu", {vcp_pin_o, vcp_pin_oe_o, vcp_busy_o, vcp_wr_o}, {8'h96, 3'h4});
		print_verdict;
	end
	// cut a hang short; the run needs well under a thousand cycles
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			print_verdict;
		end
	end
endmodule
